// >>> hw/fmc_ctrl.sv
// fuse array controller: ahb-lite register slave driving the array pins
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fmc_ctrl
    import fmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // fuse array pins
    output logic [13:0] array_addr,
    output logic array_select_n,
    output logic cmd_latch_en,
    output logic data_latch_en,
    output logic program_hv_en,
    output logic read_mode_en,
    output logic array_reset_n,
    output logic write_strobe_n,
    output logic charge_pump_en,
    output logic program_data,
    input wire logic [7:0] array_read_data,
    input wire logic array_lock,
    // secure mode
    input wire logic secure_val_sel,
    output logic [7:0] secure_mode_byte,
    output logic secure_valid
);
    logic [7:0] ctrl;
    logic [13:0] addr;
    logic select_n;
    logic [7:0] rd_data;
    logic read_done;
    fmc_lock_t lock_state;
    fmc_lock_t next_lock_state;
    logic wr_pend;
    logic [4:0] wr_ofs;
    wire addr_phase;
    wire wr_ctrl;
    wire wr_addr;
    wire wr_select;
    wire wr_key1;
    wire wr_key2;
    wire wr_capture;
    wire ctrl_open;
    wire [31:0] status_word;
    wire [31:0] next_hrdata;
    wire [4:0] ofs;

    // address phase decode; only full-word singles are expected
    assign addr_phase = hsel && hready && htrans == FMC_HTRANS_NONSEQ;
    assign ofs = haddr[4:0];

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // remember a write address phase for its data phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_pend <= 1'b0;
            wr_ofs <= FMC_OFS_CTRL;
        end
        else
        begin
            wr_pend <= addr_phase && hwrite;
            wr_ofs <= ofs;
        end
    end

    // data phase write strobes per register
    assign wr_ctrl = wr_pend && wr_ofs == FMC_OFS_CTRL;
    assign wr_addr = wr_pend && wr_ofs == FMC_OFS_ADDR;
    assign wr_select = wr_pend && wr_ofs == FMC_OFS_SELECT;
    assign wr_key1 = wr_pend && wr_ofs == FMC_OFS_UNLOCK1;
    assign wr_key2 = wr_pend && wr_ofs == FMC_OFS_UNLOCK2;
    assign wr_capture = wr_pend && wr_ofs == FMC_OFS_CAPTURE;

    // control registers freeze while the array sits in standby
    assign ctrl_open = !select_n;

    // key sequence: first key, then second key, then one select write
    always_comb
    begin
        next_lock_state = lock_state;
        case (lock_state)
            FMC_LK_IDLE:
            begin
                if (wr_key1 && hwdata == FMC_KEY1)
                    next_lock_state = FMC_LK_FIRST;
            end
            FMC_LK_FIRST:
            begin
                if (wr_key2 && hwdata == FMC_KEY2)
                    next_lock_state = FMC_LK_ARMED;
                else if (wr_pend)
                    next_lock_state = FMC_LK_IDLE;
            end
            FMC_LK_ARMED:
            begin
                // any write, the select write included, disarms
                if (wr_pend)
                    next_lock_state = FMC_LK_IDLE;
            end
            default:
                next_lock_state = FMC_LK_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            lock_state <= FMC_LK_IDLE;
        else
            lock_state <= next_lock_state;
    end

    // array select register, guarded by the key sequence
    always_ff @(posedge clk)
    begin
        if (rst)
            select_n <= 1'b1;
        else if (wr_select && lock_state == FMC_LK_ARMED)
            select_n <= hwdata[0];
    end

    // control bits and address, written only outside standby
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl <= FMC_CTRL_RESET;
            addr <= FMC_ADDR_RESET;
        end
        else
        begin
            if (wr_ctrl && ctrl_open)
                ctrl <= hwdata[FMC_CTRL_W-1:0];
            if (wr_addr && ctrl_open)
                addr <= hwdata[FMC_ADDR_W-1:0];
        end
    end

    // capture the eight-bit read word on software request
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_data <= FMC_SEC_ZEROES;
            read_done <= 1'b0;
        end
        else
        begin
            read_done <= wr_capture && ctrl_open && ctrl[FMC_B_READ_MODE];
            if (wr_capture)
                rd_data <= array_read_data;
        end
    end

    // pin drive; high voltage and pump barred in read mode and once locked
    assign array_addr = addr;
    assign array_select_n = select_n;
    assign cmd_latch_en = ctrl[FMC_B_CMD_LATCH];
    assign data_latch_en = ctrl[FMC_B_DATA_LATCH];
    assign read_mode_en = ctrl[FMC_B_READ_MODE];
    assign program_hv_en = ctrl[FMC_B_PROG_HV] && !ctrl[FMC_B_READ_MODE]
        && !array_lock;
    assign charge_pump_en = ctrl[FMC_B_PUMP] && !ctrl[FMC_B_READ_MODE]
        && !array_lock;
    assign array_reset_n = ctrl[FMC_B_ARRAY_RST_N];
    assign write_strobe_n = ctrl[FMC_B_WSTROBE_N];
    assign program_data = ctrl[FMC_B_PROG_DATA];

    // secure-mode byte comes from the first address zero read
    fmc_secure_latch u_secure (
        .clk(clk),
        .rst(rst),
        .secure_val_sel(secure_val_sel),
        .read_done(read_done),
        .read_addr_zero(addr == FMC_ADDR_ZERO),
        .read_data(rd_data),
        .secure_mode_byte(secure_mode_byte),
        .secure_valid(secure_valid)
    );

    // status word: read data, lock, valid, armed, secure byte
    assign status_word = {8'h00, secure_mode_byte, 5'h00,
        lock_state == FMC_LK_ARMED, secure_valid, array_lock, rd_data};

    // read mux; unmapped offsets read zero
    assign next_hrdata =
        ofs == FMC_OFS_CTRL ? {24'h000000, ctrl} :
        ofs == FMC_OFS_ADDR ? {18'h00000, addr} :
        ofs == FMC_OFS_SELECT ? {31'h00000000, select_n} :
        ofs == FMC_OFS_STATUS ? status_word :
        FMC_WORD_ZERO;

    // read data registered at the address phase, stands in the data phase
    always_ff @(posedge clk)
    begin
        if (rst)
            hrdata <= FMC_WORD_ZERO;
        else if (addr_phase && !hwrite)
            hrdata <= next_hrdata;
    end

    a_select_keyed: assert property (@(posedge clk) disable iff (rst)
        !$stable(select_n) |-> $past(wr_select) && $past(lock_state) == FMC_LK_ARMED)
        else $error("array select changed without unlock");
    a_key_order: assert property (@(posedge clk) disable iff (rst)
        wr_key2 && hwdata == FMC_KEY2 && lock_state == FMC_LK_FIRST
        |=> lock_state == FMC_LK_ARMED ##1 1'b1)
        else $error("ordered keys did not arm");
    a_standby_hold: assert property (@(posedge clk) disable iff (rst)
        select_n |-> !read_done)
        else $error("read completed while in standby");
    a_standby_frozen: assert property (@(posedge clk) disable iff (rst)
        select_n && (wr_ctrl || wr_addr) |=> $stable(ctrl) && $stable(addr))
        else $error("control written during standby");
    a_lock_no_prog: assert property (@(posedge clk) disable iff (rst)
        array_lock |-> !program_hv_en && !charge_pump_en)
        else $error("programming enabled while locked");
    a_read_no_hv: assert property (@(posedge clk) disable iff (rst)
        read_mode_en |-> !program_hv_en && !charge_pump_en)
        else $error("high voltage on in read mode");
    a_capture_done: assert property (@(posedge clk) disable iff (rst)
        wr_capture && !select_n && read_mode_en |=> read_done ##1 !read_done)
        else $error("capture did not pulse read done");
    a_read_data: assert property (@(posedge clk) disable iff (rst)
        addr_phase && !hwrite && ofs == FMC_OFS_CTRL |=> hrdata[7:0] == $past(ctrl))
        else $error("control readback wrong");
endmodule : fmc_ctrl
`default_nettype wire

// >>> hw/fmc_pkg.sv
// constants for the fuse memory register controller
package fmc_pkg;
    localparam int unsigned FMC_ADDR_W = 14;
    localparam int unsigned FMC_RDATA_W = 8;
    localparam int unsigned FMC_OFS_W = 5;
    // register byte offsets
    localparam logic [4:0] FMC_OFS_CTRL = 5'h00;
    localparam logic [4:0] FMC_OFS_ADDR = 5'h04;
    localparam logic [4:0] FMC_OFS_SELECT = 5'h08;
    localparam logic [4:0] FMC_OFS_UNLOCK1 = 5'h0C;
    localparam logic [4:0] FMC_OFS_UNLOCK2 = 5'h10;
    localparam logic [4:0] FMC_OFS_STATUS = 5'h14;
    localparam logic [4:0] FMC_OFS_CAPTURE = 5'h18;
    // control register fields
    localparam int unsigned FMC_CTRL_W = 8;
    localparam int unsigned FMC_B_CMD_LATCH = 0;
    localparam int unsigned FMC_B_DATA_LATCH = 1;
    localparam int unsigned FMC_B_PROG_HV = 2;
    localparam int unsigned FMC_B_READ_MODE = 3;
    localparam int unsigned FMC_B_ARRAY_RST_N = 4;
    localparam int unsigned FMC_B_WSTROBE_N = 5;
    localparam int unsigned FMC_B_PUMP = 6;
    localparam int unsigned FMC_B_PROG_DATA = 7;
    localparam logic [7:0] FMC_CTRL_RESET = 8'h30;
    localparam logic [13:0] FMC_ADDR_RESET = 14'h0000;
    localparam logic [13:0] FMC_ADDR_ZERO = 14'h0000;
    // status register fields
    localparam int unsigned FMC_S_LOCK = 8;
    localparam int unsigned FMC_S_SEC_VALID = 9;
    localparam int unsigned FMC_S_ARMED = 10;
    localparam int unsigned FMC_S_SEC_LSB = 16;
    // unlock key values, written in this order
    localparam logic [31:0] FMC_KEY1 = 32'h0000_5A5A;
    localparam logic [31:0] FMC_KEY2 = 32'h0000_A5A5;
    localparam logic [7:0] FMC_SEC_ALL_ONES = 8'hFF;
    localparam logic [7:0] FMC_SEC_ZEROES = 8'h00;
    localparam logic [1:0] FMC_HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] FMC_WORD_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        FMC_LK_IDLE = 2'b00,
        FMC_LK_FIRST = 2'b01,
        FMC_LK_ARMED = 2'b10
    } fmc_lock_t;
endpackage : fmc_pkg

// >>> hw/fmc_secure_latch.sv
// secure-mode byte latch fed by the first read of array address zero
`timescale 1ns/10ps
`default_nettype none
module fmc_secure_latch
    import fmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic secure_val_sel,
    input wire logic read_done,
    input wire logic read_addr_zero,
    input wire logic [7:0] read_data,
    output logic [7:0] secure_mode_byte,
    output logic secure_valid
);
    logic [7:0] held;
    wire first_read;

    // only the first completed address-zero read counts, later ones are ignored
    assign first_read = read_done && read_addr_zero && !secure_valid;

    // held value and valid flag live until the next reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            held <= FMC_SEC_ALL_ONES;
            secure_valid <= 1'b0;
        end
        else if (first_read)
        begin
            held <= read_data;
            secure_valid <= 1'b1;
        end
    end

    // select low forces zeroes, select high shows ones until latched
    assign secure_mode_byte = secure_val_sel ? held : FMC_SEC_ZEROES;

    a_sec_zero_out: assert property (@(posedge clk) disable iff (rst)
        !secure_val_sel |-> secure_mode_byte == FMC_SEC_ZEROES)
        else $error("secure byte not zero with select low");
    a_sec_default: assert property (@(posedge clk) disable iff (rst)
        secure_val_sel && !secure_valid |-> secure_mode_byte == FMC_SEC_ALL_ONES)
        else $error("secure byte not all ones before first read");
    a_sec_latch_hold: assert property (@(posedge clk) disable iff (rst)
        secure_valid |=> secure_valid && $stable(held))
        else $error("latched secure byte changed");
    a_sec_capture: assert property (@(posedge clk) disable iff (rst)
        read_done && read_addr_zero && !secure_valid |=> secure_valid
        && held == $past(read_data))
        else $error("first address zero read not captured");
endmodule : fmc_secure_latch
`default_nettype wire

// >>> verif/fmc_fuse_model.sv
// behavioural model of the one-time programmable fuse array
`timescale 1ns/10ps
`default_nettype none
module fmc_fuse_model
#(
    parameter int LOCK_BIT = 8191
)
(
    input wire logic [13:0] array_addr,
    input wire logic array_select_n,
    input wire logic cmd_latch_en,
    input wire logic data_latch_en,
    input wire logic program_hv_en,
    input wire logic read_mode_en,
    input wire logic array_reset_n,
    input wire logic write_strobe_n,
    input wire logic charge_pump_en,
    input wire logic program_data,
    output logic [7:0] array_read_data,
    output logic array_lock
);
    logic mem [0:8191];
    logic [7:0] rbyte;
    logic [7:0] last = 8'h00;
    logic rst_seen = 1'b0;
    // blank array reads zero
    initial
    begin
        foreach (mem[i]) mem[i] = 1'b0;
    end
    // top address bit is test mode, never a normal read
    wire rd_on = !array_select_n && read_mode_en && !array_addr[13];
    always_comb
    begin
        for (int i = 0; i < 8; i++) rbyte[i] = mem[int'(array_addr[12:3]) * 8 + i];
    end
    // released bus shows the inverse so stale data never passes
    always @(rbyte or rd_on) if (rd_on) last = rbyte;
    assign array_read_data = rd_on ? rbyte : ~last;
    assign array_lock = mem[LOCK_BIT];
    // a reset pulse while selected is needed before programming
    // one process owns the flag: deselect clears it, a selected reset pulse sets it
    always @(negedge array_reset_n or posedge array_select_n)
    begin
        if (array_select_n)
            rst_seen = 1'b0;
        else
            rst_seen = 1'b1;
    end
    // one bit per falling strobe, only with pump and high voltage on
    always @(negedge write_strobe_n)
    begin
        if (!array_select_n && rst_seen && program_hv_en && charge_pump_en && data_latch_en
            && !read_mode_en && !cmd_latch_en && !array_lock && !array_addr[13]
            && program_data)
            mem[array_addr[12:0]] = 1'b1;
    end
endmodule : fmc_fuse_model
`default_nettype wire

// >>> verif/fmc_ctrl_tb.sv
// self-checking bench for the fuse memory register controller
`timescale 1ns/10ps
`default_nettype none
module fmc_ctrl_tb
    import fmc_pkg::*;
;
    localparam int LOCK_BIT = 8191;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, secure_val_sel = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv, hrdata;
    logic hreadyout, hresp, array_select_n, cmd_latch_en, data_latch_en, program_hv_en;
    logic read_mode_en, array_reset_n, write_strobe_n, charge_pump_en, program_data;
    logic array_lock, secure_valid;
    logic [13:0] array_addr;
    logic [7:0] array_read_data, secure_mode_byte;
    logic mirror [0:8191];
    logic [12:0] a;
    int num_errors = 0, num_checks = 0, cycles = 0, seed = 32'hbede1a86;

    fmc_ctrl dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .array_addr, .array_select_n,
        .cmd_latch_en, .data_latch_en, .program_hv_en, .read_mode_en, .array_reset_n,
        .write_strobe_n, .charge_pump_en, .program_data, .array_read_data, .array_lock,
        .secure_val_sel, .secure_mode_byte, .secure_valid);
    fmc_fuse_model #(.LOCK_BIT(LOCK_BIT)) u_fuse (.array_addr, .array_select_n, .cmd_latch_en,
        .data_latch_en, .program_hv_en, .read_mode_en, .array_reset_n, .write_strobe_n,
        .charge_pump_en, .program_data, .array_read_data, .array_lock);

    // clock and hang guard
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // expected byte from the mirror of programmed bits
    function automatic logic [7:0] exp_byte(input logic [12:0] x);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = mirror[int'(x[12:3]) * 8 + i];
        return r;
    endfunction : exp_byte

    // one single ahb-lite transfer; waits on hready, no cycle count assumed
    task automatic bus(input logic w, input logic [4:0] o, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= FMC_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {27'h0, o};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        #1;
    endtask : bus

    task automatic key();
        bus(1'b1, FMC_OFS_UNLOCK1, FMC_KEY1);
        bus(1'b1, FMC_OFS_UNLOCK2, FMC_KEY2);
    endtask : key

    // reset pulse, arm buffers and pump, then one strobe pulse
    task automatic prog(input logic [12:0] x);
        logic lk;
        lk = array_lock;
        bus(1'b1, FMC_OFS_ADDR, {19'h0, x});
        bus(1'b1, FMC_OFS_CTRL, 32'h20);
        bus(1'b1, FMC_OFS_CTRL, 32'h30);
        bus(1'b1, FMC_OFS_CTRL, 32'hF6);
        chk({program_hv_en, charge_pump_en, read_mode_en, data_latch_en, program_data, cmd_latch_en},
            {~lk, ~lk, 4'b0110});
        chk(array_addr, {1'b0, x});
        bus(1'b1, FMC_OFS_CTRL, 32'hD6);
        chk(write_strobe_n, 1'b0);
        bus(1'b1, FMC_OFS_CTRL, 32'hF6);
        bus(1'b1, FMC_OFS_CTRL, 32'h30);
        if (!lk) mirror[x] = 1'b1;
    endtask : prog

    // read mode with hv and pump bits set: both must stay off
    task automatic rdb(input logic [12:0] x);
        bus(1'b1, FMC_OFS_ADDR, {19'h0, x});
        bus(1'b1, FMC_OFS_CTRL, 32'h28);
        bus(1'b1, FMC_OFS_CTRL, 32'h7C);
        chk({program_hv_en, charge_pump_en, read_mode_en}, 3'b001);
        bus(1'b1, FMC_OFS_CAPTURE, 32'h0);
        bus(1'b0, FMC_OFS_STATUS, 32'h0);
        chk(rdv[7:0], exp_byte(x));
    endtask : rdb

    initial
    begin
        foreach (mirror[i]) mirror[i] = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, FMC_OFS_STATUS, 32'h0);
        chk(rdv, 32'h00FF0000);
        chk(secure_mode_byte, FMC_SEC_ALL_ONES);
        bus(1'b0, 5'h1C, 32'h0);
        chk(rdv, FMC_WORD_ZERO);
        // standby: control writes must not land
        bus(1'b1, FMC_OFS_CTRL, 32'hFF);
        bus(1'b1, FMC_OFS_ADDR, 32'h1234);
        chk({array_addr, array_select_n, read_mode_en, array_reset_n, write_strobe_n},
            {14'h0, 4'b1011});
        bus(1'b1, FMC_OFS_SELECT, 32'h0);
        chk(array_select_n, 1'b1);
        bus(1'b1, FMC_OFS_UNLOCK2, FMC_KEY2);
        bus(1'b1, FMC_OFS_UNLOCK1, FMC_KEY1);
        bus(1'b1, FMC_OFS_SELECT, 32'h0);
        chk(array_select_n, 1'b1);
        key();
        bus(1'b0, FMC_OFS_STATUS, 32'h0);
        chk(rdv[FMC_S_ARMED], 1'b1);
        bus(1'b1, FMC_OFS_SELECT, 32'h0);
        chk(array_select_n, 1'b0);
        // command latch bit and control readback
        bus(1'b1, FMC_OFS_CTRL, 32'h31);
        chk(cmd_latch_en, 1'b1);
        bus(1'b0, FMC_OFS_CTRL, 32'h0);
        chk(rdv, 32'h31);
        bus(1'b1, FMC_OFS_CTRL, 32'h30);
        chk({cmd_latch_en, hresp, program_data}, 3'b000);
        // first address-zero read latches the secure byte
        prog(13'h3);
        rdb(13'h0);
        chk(rdv, 32'h00080208);
        prog(13'h5);
        rdb(13'h0);
        chk({secure_valid, secure_mode_byte}, 9'h108);
        @(posedge clk);
        secure_val_sel <= 1'b0;
        @(posedge clk);
        #1;
        chk(secure_mode_byte, FMC_SEC_ZEROES);
        @(posedge clk);
        secure_val_sel <= 1'b1;
        repeat (10)
        begin
            a = 13'($random(seed));
            if (a == 13'(LOCK_BIT)) a = 13'h1;
            prog(a);
            rdb(a);
            rdb(13'($random(seed)));
        end
        // security lock makes the array read only
        prog(13'(LOCK_BIT));
        chk(array_lock, 1'b1);
        prog(13'h0F0);
        rdb(13'h0F0);
        chk(rdv[FMC_S_LOCK], 1'b1);
        key();
        bus(1'b1, FMC_OFS_SELECT, 32'h1);
        chk(array_select_n, 1'b1);
        // mid-run reset drops the latch back to its default
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({secure_valid, secure_mode_byte, array_select_n}, 10'h1FF);
        key();
        bus(1'b1, FMC_OFS_SELECT, 32'h0);
        rdb(13'h0);
        chk({secure_valid, secure_mode_byte}, {1'b1, exp_byte(13'h0)});
        tally_and_finish();
    end
endmodule : fmc_ctrl_tb
`default_nettype wire
